// file: rtl/mfc_consts.svh
// Constants for the Modbus frame check and reply block
// Functional notes
// [RL1] ASCII LRC: byte sum modulo 256, address to data
// [RL2] Send negated sum as two hex chars
// [RL3] RTU CRC accumulator preset to all ones
// [RL4] XOR each byte into accumulator low byte
// [RL5] Shift right, XOR polynomial when one out
// [RL6] Exactly eight shift steps per byte
// [RL7] Final accumulator is the CRC, uninverted
// [RL8] CRC low byte sent before high byte
// [RL9] Read reply: address, function, count, words, check
// [RL10] Write command fields arrive high byte first
// [RL11] Write reply echoes the command exactly
// [RL12] ASCII bytes as two hex chars, high first
// [RL13] ASCII frame: colon start, CR LF end
// [RL14] RTU frame bounded by long silent interval
// [RL15] Address zero broadcast: act, never reply
`ifndef MFC_CONSTS_SVH
`define MFC_CONSTS_SVH
`define MB_CLK_NS      8
`define MB_SILENT_NS   10000000
`define MB_SILENT_CYC  ((`MB_SILENT_NS + `MB_CLK_NS - 1) / `MB_CLK_NS)
`define MB_MAX_WORDS   20
`define MB_CRC_PRESET  16'hffff
`define MB_CRC_POLY    16'ha001
`define MB_LRC_RESET   8'h00
`define MB_CHR_COLON   8'h3a
`define MB_CHR_CR      8'h0d
`define MB_CHR_LF      8'h0a
`define MB_FN_READ     8'h03
`define MB_FN_WRITE    8'h06
`define MB_BCAST       8'h00
`define MB_LEN_RTU     4'h8
`define MB_LEN_ASCII   4'h7
`define MB_BUF_DEPTH   8
`define MB_IX_ADDR     0
`define MB_IX_FUNC     1
`define MB_IX_REG_HI   2
`define MB_IX_REG_LO   3
`define MB_IX_VAL_HI   4
`define MB_IX_VAL_LO   5
`define MB_READ_HDR    8'h03
`define MB_WRITE_LEN   8'h06
`endif

// file: rtl/mfc_pkg.sv
// Types shared by the Modbus frame check and reply block
package mfc_pkg;
  // Line coding selected by the drive configuration
  typedef enum logic {MFC_MODE_RTU, MFC_MODE_ASCII} mfc_mode_type;
  // ASCII receive framing
  typedef enum {RX_HUNT, RX_BODY, RX_LF} mfc_rx_state_type;
  // Reply sender
  typedef enum {TX_IDLE, TX_COLON, TX_LOAD, TX_FETCH, TX_HI, TX_LO, TX_BIN, TX_CR, TX_LF} mfc_tx_state_type;
endpackage : mfc_pkg

// file: rtl/mfc_check_engine.sv
// Byte-wide CRC-16 and LRC accumulator pair
`timescale 1ns/10ps
`include "mfc_consts.svh"
module mfc_check_engine (
  input  wire logic        sys_clk,
  input  wire logic        resetn,
  input  wire logic        clr,
  input  wire logic        feed,
  input  wire logic [7:0]  data,
  output logic      [15:0] crc_q,
  output logic      [7:0]  sum_q
);
  import mfc_pkg::*;

  // One whole byte through the reflected CRC, all eight steps in one clock
  function automatic logic [15:0] crc_byte(input logic [15:0] acc, input logic [7:0] b);
    logic [15:0] r;
    r = acc ^ {8'h00, b}; // RL4
    for (int i = 0; i < 8; i++) begin // RL6
      r = r[0] ? ((r >> 1) ^ `MB_CRC_POLY) : (r >> 1); // RL5
    end
    return r;
  endfunction : crc_byte

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  // CRC accumulator; value read out as is, never inverted
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      crc_q <= `MB_CRC_PRESET;
    end else if (clr) begin
      crc_q <= `MB_CRC_PRESET; // RL3
    end else if (feed) begin
      crc_q <= crc_byte(crc_q, data); // RL7
    end
  end

  // LRC running sum, wraps naturally at 8 bits
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      sum_q <= `MB_LRC_RESET;
    end else if (clr) begin
      sum_q <= `MB_LRC_RESET;
    end else if (feed) begin
      sum_q <= sum_q + data; // RL1
    end
  end

  // Clear wins over a byte offered in the same cycle
  preset_on_clear_a: assert property (clr |=> crc_q == 16'hffff && sum_q == 8'h00) // RL3
    else $error("check engine not preset after clear");
  // Single-bit byte from a fresh preset gives the known residue
  crc_known_a: assert property (clr ##1 (feed && !clr && data == 8'h01) |=> crc_q == 16'h807e) // RL5
    else $error("crc of byte 01 after preset is wrong");
  // Idle cycles leave both sums untouched
  hold_when_idle_a: assert property (!clr && !feed |=> $stable(crc_q) && $stable(sum_q)) // RL7
    else $error("check sums moved without a byte");
  // Sum tracks the byte added, modulo 256
  lrc_adds_a: assert property (feed && !clr |=> sum_q == 8'($past(sum_q) + $past(data))) // RL1
    else $error("lrc sum did not add the byte");
endmodule : mfc_check_engine

// file: rtl/mfc_frame_responder.sv
// Modbus slave frame checker and read/write reply formatter
`timescale 1ns/10ps
`include "mfc_consts.svh"
module mfc_frame_responder #(
  parameter int MAX_WORDS  = `MB_MAX_WORDS,
  parameter int SILENT_CYC = `MB_SILENT_CYC
) (
  input  wire logic                 sys_clk,
  input  wire logic                 resetn,
  input  wire mfc_pkg::mfc_mode_type mode,
  input  wire logic [7:0]           own_addr,
  input  wire logic [7:0]           rx_data,
  input  wire logic                 rx_valid,
  input  wire logic                 tx_ready,
  input  wire logic [15:0]          reg_rd_data,
  output logic      [7:0]           tx_data_q,
  output logic                      tx_valid_q,
  output logic                      tx_busy_q,
  output logic      [15:0]          reg_addr_q,
  output logic                      reg_rd_en_q,
  output logic                      reg_wr_en_q,
  output logic      [15:0]          reg_wr_data_q,
  output logic                      frame_err_q
);
  import mfc_pkg::*;

  localparam int SIL_W = $clog2(SILENT_CYC + 1);

  // Parameters the byte counters cannot hold
  if (MAX_WORDS < 1 || MAX_WORDS > 125 || SILENT_CYC < 2) begin : g_bad_param
    $error("mfc_frame_responder: parameter out of range");
  end

  // ASCII hex digit to {valid, nibble}; upper case only
  function automatic logic [4:0] hex_val(input logic [7:0] c);
    if (c >= 8'h30 && c <= 8'h39) return {1'b1, 4'(c - 8'h30)};
    if (c >= 8'h41 && c <= 8'h46) return {1'b1, 4'(c - 8'h37)};
    return 5'h00;
  endfunction : hex_val

  // Nibble to upper-case ASCII hex digit
  function automatic logic [7:0] hex_char(input logic [3:0] n);
    return (n < 4'ha) ? (8'h30 + {4'h0, n}) : (8'h37 + {4'h0, n});
  endfunction : hex_char

  logic             is_ascii;     // Current line coding
  logic [SIL_W-1:0] sil_cnt_q;    // Idle-line timer
  logic             sil_hit;      // Silent interval just completed
  mfc_rx_state_type rx_state_q;   // ASCII framing state
  logic             phase_q;      // Low nibble expected next
  logic [3:0]       hi_nib_q;     // Held high nibble
  logic             bad_q;        // Non-hex character seen
  logic [3:0]       rx_cnt_q;     // Bytes in frame, saturating
  logic [7:0]       rx_buf_q [0:`MB_BUF_DEPTH-1];
  logic [4:0]       hexv;         // Decoded incoming character
  logic             rx_start;     // New frame begins
  logic             byte_stb;     // One frame byte complete
  logic [7:0]       byte_val;     // Its value
  logic             frame_end;    // Frame delimiter reached
  logic             chk_ok;       // Length and check field good
  logic             bcast;        // Broadcast address
  logic             accept;       // Frame taken for action
  logic             wr_go;        // Perform a register write
  logic             tx_go;        // Start a reply
  logic [15:0]      rx_words;     // Requested word count
  logic [15:0]      rx_crc;
  logic [7:0]       rx_sum;
  mfc_tx_state_type tx_state_q;   // Reply sender state
  logic             tx_ascii_q;   // Coding latched for the reply
  logic [7:0]       tx_addr_q;    // Reply address
  logic [7:0]       tx_func_q;    // Reply function
  logic [6:0]       tx_words_q;   // Words to return
  logic [15:0]      tx_base_q;    // First register to read
  logic [7:0]       tx_echo_q [0:3];
  logic [7:0]       tx_idx_q;     // Logical byte index in reply
  logic             fetched_q;    // Word for this pair already read
  logic [15:0]      word_q;       // Register word being sent
  logic [7:0]       cur_q;        // Byte being sent
  logic [7:0]       tx_dlen;      // Bytes covered by the check
  logic [7:0]       tx_last;      // Index of final binary byte
  logic [7:0]       pick;         // Byte for the current index
  logic             need_fetch;
  logic             fetch_req;
  logic             tx_feed;
  logic             tx_acc;       // Character taken by the UART
  logic [15:0]      tx_crc;
  logic [7:0]       tx_sum;
  logic [7:0]       lrc_neg;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  assign is_ascii = (mode == MFC_MODE_ASCII);
  assign hexv     = hex_val(rx_data);

  // Idle-line timer, restarted by every character
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      sil_cnt_q <= '0;
    end else if (rx_valid) begin
      sil_cnt_q <= '0;
    end else if (sil_cnt_q != SIL_W'(SILENT_CYC)) begin
      sil_cnt_q <= sil_cnt_q + 1'b1;
    end
  end
  assign sil_hit = !rx_valid && (sil_cnt_q == SIL_W'(SILENT_CYC - 1)); // RL14

  // Frame start and byte assembly for both codings
  assign rx_start  = is_ascii ? (rx_valid && rx_data == `MB_CHR_COLON) : sil_hit; // RL13
  assign byte_stb  = is_ascii ? (rx_valid && rx_state_q == RX_BODY && hexv[4] && phase_q) : rx_valid;
  assign byte_val  = is_ascii ? {hi_nib_q, hexv[3:0]} : rx_data; // RL12
  // Delimiters: CR LF in ASCII, silence after data in RTU
  assign frame_end = is_ascii ? (rx_valid && rx_state_q == RX_LF && rx_data == `MB_CHR_LF)
                              : (sil_hit && rx_cnt_q != 4'h0); // RL14

  // ASCII framing; a colon restarts the frame from any state
  always_ff @(posedge sys_clk) begin
    if (!resetn || !is_ascii) begin
      rx_state_q <= RX_HUNT;
    end else if (rx_valid) begin
      if (rx_data == `MB_CHR_COLON) begin
        rx_state_q <= RX_BODY; // RL13
      end else begin
        unique case (rx_state_q)
          RX_HUNT: rx_state_q <= RX_HUNT;
          RX_BODY: if (rx_data == `MB_CHR_CR) rx_state_q <= RX_LF;
          RX_LF:   rx_state_q <= RX_HUNT;
        endcase
      end
    end
  end

  // Nibble pairing, error flag and byte count
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      phase_q  <= 1'b0;
      hi_nib_q <= 4'h0;
      bad_q    <= 1'b0;
      rx_cnt_q <= 4'h0;
    end else if (rx_start) begin
      phase_q  <= 1'b0;
      bad_q    <= 1'b0;
      rx_cnt_q <= 4'h0;
    end else begin
      // Saturate so long frames fail the length test
      if (byte_stb && rx_cnt_q != 4'hf) rx_cnt_q <= rx_cnt_q + 4'h1;
      if (is_ascii && rx_valid && rx_state_q == RX_BODY && rx_data != `MB_CHR_CR) begin
        if (!hexv[4]) begin
          bad_q <= 1'b1;
        end else begin
          phase_q  <= ~phase_q; // RL12
          hi_nib_q <= hexv[3:0];
        end
      end
    end
  end

  // Frame store; bytes past the buffer are counted only
  always_ff @(posedge sys_clk) begin
    if (byte_stb && !rx_cnt_q[3]) begin
      rx_buf_q[rx_cnt_q[2:0]] <= byte_val;
    end
  end

  // Receive check: residue must come out zero
  mfc_check_engine u_rx_chk (
    .sys_clk (sys_clk),
    .resetn  (resetn),
    .clr     (rx_start),
    .feed    (byte_stb),
    .data    (byte_val),
    .crc_q   (rx_crc),
    .sum_q   (rx_sum)
  );

  // Sum over data plus LRC is zero; CRC over data plus CRC is zero
  assign chk_ok = is_ascii ? (rx_sum == 8'h00 && rx_cnt_q == `MB_LEN_ASCII && !phase_q && !bad_q) // RL1
                           : (rx_crc == 16'h0000 && rx_cnt_q == `MB_LEN_RTU); // RL8
  assign bcast    = (rx_buf_q[`MB_IX_ADDR] == `MB_BCAST);
  assign rx_words = {rx_buf_q[`MB_IX_VAL_HI], rx_buf_q[`MB_IX_VAL_LO]};
  // Frames arriving while a reply is going out are dropped
  assign accept   = frame_end && chk_ok && !tx_busy_q && (bcast || rx_buf_q[`MB_IX_ADDR] == own_addr);
  assign wr_go    = accept && rx_buf_q[`MB_IX_FUNC] == `MB_FN_WRITE;
  assign tx_go    = accept && !bcast && (wr_go || (rx_buf_q[`MB_IX_FUNC] == `MB_FN_READ
                    && rx_words != 16'h0000 && rx_words <= 16'(MAX_WORDS))); // RL15

  // Bad check or length flagged for one cycle
  always_ff @(posedge sys_clk) begin
    if (!resetn) frame_err_q <= 1'b0;
    else         frame_err_q <= frame_end && !chk_ok;
  end

  // Reply context captured so a new frame cannot disturb it
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      tx_ascii_q <= 1'b0;
      tx_addr_q  <= 8'h00;
      tx_func_q  <= 8'h00;
      tx_words_q <= 7'h00;
      tx_base_q  <= 16'h0000;
    end else if (tx_go) begin
      tx_ascii_q <= is_ascii;
      tx_addr_q  <= rx_buf_q[`MB_IX_ADDR];
      tx_func_q  <= rx_buf_q[`MB_IX_FUNC];
      tx_words_q <= rx_words[6:0];
      tx_base_q  <= {rx_buf_q[`MB_IX_REG_HI], rx_buf_q[`MB_IX_REG_LO]};
    end
  end

  // Register address and value bytes kept for the echo
  for (genvar g = 0; g < 4; g++) begin : g_echo
    always_ff @(posedge sys_clk) begin
      if (!resetn)    tx_echo_q[g] <= 8'h00;
      else if (tx_go) tx_echo_q[g] <= rx_buf_q[g + `MB_IX_REG_HI];
    end
  end

  // Register port: write on command, reads fetched while replying
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      reg_addr_q    <= 16'h0000;
      reg_rd_en_q   <= 1'b0;
      reg_wr_en_q   <= 1'b0;
      reg_wr_data_q <= 16'h0000;
    end else begin
      reg_rd_en_q <= fetch_req;
      reg_wr_en_q <= wr_go;
      if (wr_go) begin
        // Address and value both high byte first
        reg_addr_q    <= {rx_buf_q[`MB_IX_REG_HI], rx_buf_q[`MB_IX_REG_LO]}; // RL10
        reg_wr_data_q <= rx_words; // RL10
      end else if (fetch_req) begin
        reg_addr_q <= tx_base_q + {8'h00, 8'(tx_idx_q - `MB_READ_HDR) >> 1};
      end
    end
  end

  // Reply byte plan: header, payload, then check bytes
  assign tx_dlen = (tx_func_q == `MB_FN_READ) ? (`MB_READ_HDR + {tx_words_q, 1'b0}) : `MB_WRITE_LEN;
  assign tx_last = tx_ascii_q ? tx_dlen : (tx_dlen + 8'h01);
  assign lrc_neg = 8'h00 - tx_sum; // RL2

  // Byte for the current index
  always_comb begin
    pick = 8'h00;
    if (tx_idx_q == 8'h00) begin
      pick = tx_addr_q;
    end else if (tx_idx_q == 8'h01) begin
      pick = tx_func_q;
    end else if (tx_idx_q == tx_dlen) begin
      pick = tx_ascii_q ? lrc_neg : tx_crc[7:0]; // RL8
    end else if (tx_idx_q > tx_dlen) begin
      pick = tx_crc[15:8];
    end else if (tx_func_q == `MB_FN_WRITE) begin
      pick = tx_echo_q[2'(tx_idx_q - 8'h02)]; // RL11
    end else if (tx_idx_q == 8'h02) begin
      pick = {tx_words_q, 1'b0}; // RL9
    end else begin
      pick = tx_idx_q[0] ? word_q[15:8] : word_q[7:0]; // RL9
    end
  end

  // Odd payload index of a read reply starts a new word
  assign need_fetch = tx_func_q == `MB_FN_READ && tx_idx_q >= `MB_READ_HDR && tx_idx_q < tx_dlen
                      && tx_idx_q[0] && !fetched_q;
  assign fetch_req  = tx_state_q == TX_LOAD && need_fetch;
  assign tx_feed    = tx_state_q == TX_LOAD && !need_fetch && tx_idx_q < tx_dlen;
  assign tx_acc     = tx_valid_q && tx_ready;

  // Transmit check; frozen once payload bytes stop
  mfc_check_engine u_tx_chk (
    .sys_clk (sys_clk),
    .resetn  (resetn),
    .clr     (tx_go),
    .feed    (tx_feed),
    .data    (pick),
    .crc_q   (tx_crc),
    .sum_q   (tx_sum)
  );

  // Reply sender; each character held until the UART takes it
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      tx_state_q <= TX_IDLE;
      tx_valid_q <= 1'b0;
      tx_data_q  <= 8'h00;
      tx_busy_q  <= 1'b0;
      tx_idx_q   <= 8'h00;
      fetched_q  <= 1'b0;
      word_q     <= 16'h0000;
      cur_q      <= 8'h00;
    end else begin
      unique case (tx_state_q)
        TX_IDLE: if (tx_go) begin
          tx_busy_q <= 1'b1;
          tx_idx_q  <= 8'h00;
          fetched_q <= 1'b0;
          if (is_ascii) begin
            tx_valid_q <= 1'b1;
            tx_data_q  <= `MB_CHR_COLON; // RL13
            tx_state_q <= TX_COLON;
          end else begin
            tx_state_q <= TX_LOAD;
          end
        end
        TX_COLON: if (tx_acc) begin
          tx_valid_q <= 1'b0;
          tx_state_q <= TX_LOAD;
        end
        TX_LOAD: if (need_fetch) begin
          tx_state_q <= TX_FETCH;
        end else begin
          cur_q      <= pick;
          fetched_q  <= 1'b0;
          tx_valid_q <= 1'b1;
          if (tx_ascii_q) begin
            tx_data_q  <= hex_char(pick[7:4]); // RL12
            tx_state_q <= TX_HI;
          end else begin
            tx_data_q  <= pick;
            tx_state_q <= TX_BIN;
          end
        end
        // Read data is valid while the read strobe is high
        TX_FETCH: begin
          word_q     <= reg_rd_data;
          fetched_q  <= 1'b1;
          tx_state_q <= TX_LOAD;
        end
        TX_HI: if (tx_acc) begin
          tx_data_q  <= hex_char(cur_q[3:0]); // RL2
          tx_state_q <= TX_LO;
        end
        TX_LO, TX_BIN: if (tx_acc) begin
          tx_valid_q <= 1'b0;
          if (tx_idx_q != tx_last) begin
            tx_idx_q   <= tx_idx_q + 8'h01;
            tx_state_q <= TX_LOAD;
          end else if (tx_ascii_q) begin
            tx_valid_q <= 1'b1;
            tx_data_q  <= `MB_CHR_CR; // RL13
            tx_state_q <= TX_CR;
          end else begin
            tx_busy_q  <= 1'b0;
            tx_state_q <= TX_IDLE;
          end
        end
        TX_CR: if (tx_acc) begin
          tx_data_q  <= `MB_CHR_LF;
          tx_state_q <= TX_LF;
        end
        TX_LF: if (tx_acc) begin
          tx_valid_q <= 1'b0;
          tx_busy_q  <= 1'b0;
          tx_state_q <= TX_IDLE;
        end
      endcase
    end
  end

  // Offered character stays put until taken
  tx_hold_a: assert property (tx_valid_q && !tx_ready |=> tx_valid_q && $stable(tx_data_q))
    else $error("tx character changed before it was taken");
  ascii_start_a: assert property (tx_go && is_ascii |=> tx_valid_q && tx_data_q == 8'h3a) // RL13
    else $error("ascii reply did not open with a colon");
  ascii_end_a: assert property (tx_state_q == TX_CR && tx_acc |-> tx_data_q == 8'h0d ##1
    (tx_state_q == TX_LF && tx_valid_q && tx_data_q == 8'h0a)) // RL13
    else $error("ascii reply not closed by CR LF");
  sequence lrc_hi_s;
    tx_state_q == TX_HI && tx_data_q == hex_char(lrc_neg[7:4]);
  endsequence
  sequence lrc_lo_s;
    tx_state_q == TX_LO && tx_data_q == hex_char(lrc_neg[3:0]);
  endsequence
  lrc_send_a: assert property (tx_state_q == TX_HI && tx_idx_q == tx_dlen && tx_acc |-> lrc_hi_s ##1 lrc_lo_s) // RL2
    else $error("lrc characters wrong or out of order");
  crc_order_a: assert property (tx_state_q == TX_BIN && tx_idx_q >= tx_dlen
    |-> tx_data_q == ((tx_idx_q == tx_dlen) ? tx_crc[7:0] : tx_crc[15:8])) // RL8
    else $error("crc bytes wrong or swapped");
  read_count_a: assert property (tx_state_q inside {TX_HI, TX_BIN} && tx_idx_q == 8'h02
    && tx_func_q == 8'h03 |-> cur_q == {tx_words_q, 1'b0}) // RL9
    else $error("read reply byte count not twice the words");
  write_echo_a: assert property (tx_state_q inside {TX_HI, TX_BIN} && tx_func_q == 8'h06
    && tx_idx_q >= 8'h02 && tx_idx_q < 8'h06 |-> cur_q == tx_echo_q[2'(tx_idx_q - 8'h02)]) // RL11
    else $error("write reply does not echo the command");
  bcast_quiet_a: assert property (frame_end && bcast && !tx_busy_q |=> !tx_busy_q [*2]) // RL15
    else $error("reply started for a broadcast frame");
  write_issue_a: assert property (wr_go |=> reg_wr_en_q && reg_wr_data_q == $past(rx_words)
    && reg_addr_q == {$past(rx_buf_q[2]), $past(rx_buf_q[3])}) // RL10
    else $error("register write not issued from the command");
endmodule : mfc_frame_responder

// file: tb/mfc_master_model.sv
// Modbus master station model: frames commands and gathers replies
`timescale 1ns/10ps
module mfc_master_model #(
  parameter int SILENT = 20
) (
  input  wire logic       sys_clk,
  output logic      [7:0] rx_data,
  output logic            rx_valid,
  output logic            tx_ready,
  input  wire logic [7:0] tx_data_q,
  input  wire logic       tx_valid_q
);
  logic [7:0]   cur;   // Character on the line while valid
  logic         tgl;   // Idle scramble so a stale byte never looks valid
  bit           slow;  // Stall the reply stream at random
  bit           bad;   // Corrupt the check of the next frame
  byte unsigned got[$]; // Reply characters taken
  // Idle line alternates between the complement of the last byte and the byte itself
  assign rx_data = rx_valid ? cur : (~cur ^ {8{tgl}});
  initial begin
    cur = 8'h00;
    tgl = 1'b0;
    rx_valid = 1'b0;
    tx_ready = 1'b1;
  end
  // Scramble toggle and random stalls, changed off the sampling edge
  always @(negedge sys_clk) begin
    tgl <= ~tgl;
    tx_ready <= !slow || ($urandom_range(1, 0) == 1);
  end
  // Collect every character taken by the handshake
  always @(posedge sys_clk) begin
    if (tx_valid_q && tx_ready) got.push_back(tx_data_q);
  end
  // CRC-16 over a byte list, no final inversion
  function automatic logic [15:0] crc16(byte unsigned b[$]);
    logic [15:0] c = 16'hffff;
    foreach (b[i]) begin
      c ^= {8'h00, b[i]};
      repeat (8) c = c[0] ? ((c >> 1) ^ 16'ha001) : (c >> 1);
    end
    return c;
  endfunction : crc16
  // Upper-case hex digit
  function automatic byte unsigned hx(int n);
    return (n < 10) ? 8'(8'h30 + n) : 8'(8'h37 + n);
  endfunction : hx
  // Whole line image of a frame in either coding
  function automatic void enc(byte unsigned b[$], bit asc, ref byte unsigned o[$]);
    logic [15:0]  c;
    byte unsigned s;
    o = {};
    s = 8'h00;
    if (!asc) begin
      c = crc16(b);
      o = {b, c[7:0], c[15:8]};
      return;
    end
    o.push_back(8'h3a);
    foreach (b[i]) s += b[i];
    b.push_back(8'h00 - s);
    foreach (b[i]) o = {o, hx(b[i] >> 4), hx(b[i] & 15)};
    o = {o, 8'h0d, 8'h0a};
  endfunction : enc
  // Send one frame after a silent gap, characters back to back
  task automatic send(byte unsigned b[$], bit asc);
    byte unsigned o[$];
    enc(b, asc, o);
    if (bad) o[o.size() - (asc ? 3 : 1)] ^= 8'h01;
    repeat (SILENT + 2) @(negedge sys_clk);
    foreach (o[i]) begin
      cur <= o[i];
      rx_valid <= 1'b1;
      @(negedge sys_clk);
    end
    rx_valid <= 1'b0;
  endtask : send
endmodule : mfc_master_model

// file: tb/mfc_frame_responder_test.sv
// Self-checking bench for the Modbus frame check and reply block
`timescale 1ns/10ps
module mfc_frame_responder_test;
  import mfc_pkg::*;
  localparam int NW = 4;  // Short word limit so the boundary is cheap
  localparam int SC = 20; // Short silent interval
  logic         sys_clk, resetn, tx_ready, rx_valid, tx_valid_q, tx_busy_q;
  logic         reg_rd_en_q, reg_wr_en_q, frame_err_q;
  mfc_mode_type mode;
  logic [7:0]   own_addr, rx_data, tx_data_q;
  logic [15:0]  reg_addr_q, reg_wr_data_q, reg_rd_data, wr_a, wr_d;
  int           n_mismatch = 0, checks_done = 0, cyc = 0, n_wr = 0, n_err = 0;
  byte unsigned z[$];     // No reply expected
  // Register file of the bench: word is a known function of address,
  // valid only under the read strobe so a missed strobe shows in the reply
  assign reg_rd_data = reg_rd_en_q ? 16'(reg_addr_q * 16'h0003 + 16'h1770) : 16'hbad0;
  mfc_frame_responder #(.MAX_WORDS(NW), .SILENT_CYC(SC)) i_mfc_frame_responder (
    .sys_clk(sys_clk), .resetn(resetn), .mode(mode), .own_addr(own_addr),
    .rx_data(rx_data), .rx_valid(rx_valid), .tx_ready(tx_ready),
    .reg_rd_data(reg_rd_data), .tx_data_q(tx_data_q), .tx_valid_q(tx_valid_q),
    .tx_busy_q(tx_busy_q), .reg_addr_q(reg_addr_q), .reg_rd_en_q(reg_rd_en_q),
    .reg_wr_en_q(reg_wr_en_q), .reg_wr_data_q(reg_wr_data_q), .frame_err_q(frame_err_q));
  mfc_master_model #(.SILENT(SC)) i_mfc_master_model (
    .sys_clk(sys_clk), .rx_data(rx_data), .rx_valid(rx_valid),
    .tx_ready(tx_ready), .tx_data_q(tx_data_q), .tx_valid_q(tx_valid_q));
  // 125 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  // Count writes and errors; cut a hang short
  always @(posedge sys_clk) begin
    cyc++;
    if (reg_wr_en_q) begin
      n_wr++;
      wr_a = reg_addr_q;
      wr_d = reg_wr_data_q;
    end
    if (frame_err_q) n_err++;
    if (cyc == 20000) begin
      n_mismatch++;
      close_out();
    end
  end
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic close_out();
    $display("Checks %0d, mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : close_out
  // One command, then compare reply, writes and errors with the model
  task automatic xact(string nm, byte unsigned c[$], byte unsigned r[$], int we, int er);
    byte unsigned e[$];
    int w0, e0, k;
    w0 = n_wr;
    e0 = n_err;
    i_mfc_master_model.got = {};
    i_mfc_master_model.send(c, mode);
    repeat (SC + 5) @(negedge sys_clk);
    k = 0;
    while (tx_busy_q !== 1'b0 && k < 2000) begin
      @(negedge sys_clk);
      k++;
    end
    chk({nm, " busy"}, tx_busy_q, 0);
    e = {};
    if (r.size() > 0) i_mfc_master_model.enc(r, mode, e);
    chk({nm, " len"}, i_mfc_master_model.got.size(), e.size());
    foreach (e[i]) chk({nm, " chr"}, i_mfc_master_model.got[i], e[i]);
    chk({nm, " wr"}, n_wr - w0, we);
    chk({nm, " err"}, n_err - e0, er);
    $display("%s done", nm);
  endtask : xact
  initial begin
    byte unsigned c[$], r[$];
    logic [15:0]  v, w;
    int           n;
    resetn = 1'b0;
    mode = MFC_MODE_RTU;
    own_addr = 8'h01;
    void'($urandom(32'h3ce9));
    repeat (5) @(negedge sys_clk);
    resetn = 1'b1;
    c = {8'h01, 8'h03, 8'h21, 8'h02, 8'h00, 8'h02};
    chk("crc ref", i_mfc_master_model.crc16(c), 16'hf76f);
    for (int m = 0; m < 2; m++) begin
      mode = mfc_mode_type'(m);
      // Address 01 in RTU drives the known single-byte residue; below 80 so the flip is never broadcast
      own_addr = m[0] ? 8'($urandom_range(127, 1)) : 8'h01;
      i_mfc_master_model.slow = m[0];
      // Reads: a random count, then the largest allowed
      for (int j = 0; j < 2; j++) begin
        n = j ? NW : $urandom_range(NW - 1, 1);
        v = 16'($urandom);
        c = {own_addr, 8'h03, v[15:8], v[7:0], 8'h00, 8'(n)};
        r = {own_addr, 8'h03, 8'(2 * n)};
        for (int i = 0; i < n; i++) begin
          w = 16'((v + i) * 3 + 16'h1770);
          r = {r, w[15:8], w[7:0]};
        end
        xact("read", c, r, 0, 0);
      end
      v = 16'($urandom);
      w = 16'($urandom);
      c = {own_addr, 8'h06, v[15:8], v[7:0], w[15:8], w[7:0]};
      xact("write", c, c, 1, 0);
      chk("wr addr", wr_a, v);
      chk("wr data", wr_d, w);
      c[0] = 8'h00;
      xact("bcast", c, z, 1, 0);
      c[0] = own_addr ^ 8'h80;
      xact("other", c, z, 0, 0);
      c = {own_addr, 8'h03, 8'h00, 8'h10, 8'h00, 8'(NW + 1)};
      xact("too many", c, z, 0, 0);
      c[5] = 8'h00;
      xact("no words", c, z, 0, 0);
      i_mfc_master_model.bad = 1'b1;
      xact("bad check", c, z, 0, 1);
      i_mfc_master_model.bad = 1'b0;
    end
    close_out();
  end
endmodule : mfc_frame_responder_test
